// File: sdis_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SDIS_REGS_SVH
`define SDIS_REGS_SVH

// system bus address map
`define SDIS_MEM_SPACE_BIT 29
`define SDIS_BA_LSB 22
`define SDIS_OFS_MODE 8'h00
`define SDIS_OFS_RTR 8'h04
`define SDIS_OFS_CFG 8'h08
`define SDIS_OFS_LPR 8'h0c
`define SDIS_OFS_TYPE 8'h10
`define SDIS_OFS_STATUS 8'h14

// register fields
`define SDIS_MODE_W 3
`define SDIS_RTR_W 12
`define SDIS_CFG_CAS_LSB 0
`define SDIS_CFG_DLL_BIT 4
`define SDIS_CFG_HT_BIT 5
`define SDIS_CFG_WEAK_BIT 6
`define SDIS_LP_ARRAY_LSB 0
`define SDIS_LP_DRIVE_LSB 5
`define SDIS_TYPE_W 2

// reset values
`define SDIS_MODE_RST 3'h0
`define SDIS_RTR_RST 12'h000
`define SDIS_CFG_RST 7'h03
`define SDIS_LPR_RST 7'h00
`define SDIS_TYPE_RST 2'h0

// memory address bits of mode register and precharge commands
`define SDIS_A_BL_LSB 0
`define SDIS_A_CAS_LSB 4
`define SDIS_A_DLL_RST 8
`define SDIS_A_AP 10
`define SDIS_A_EMR_ARRAY_LSB 0
`define SDIS_A_EMR_DRIVE_LSB 5
`define SDIS_A_EMR1_WEAK 1
`define SDIS_A_EMR2_HT 7
`define SDIS_BL8_CODE 3'h3

// timing
`define SDIS_CLK_PERIOD_NS 8
`define SDIS_POWERUP_NS 200000
`define SDIS_POWERUP_CYC \
	((`SDIS_POWERUP_NS + `SDIS_CLK_PERIOD_NS - 1) / `SDIS_CLK_PERIOD_NS)
`define SDIS_DLL_LOCK_CLKS 200

`endif

// File: sdis_pkg.sv
// types shared by the init command sequencer
`default_nettype none
package sdis_pkg;

	typedef enum logic [2:0]
	{
		SDIS_MODE_NORMAL = 3'h0,
		SDIS_MODE_NOP = 3'h1,
		SDIS_MODE_PRECHARGE = 3'h2,
		SDIS_MODE_LOAD_MR = 3'h3,
		SDIS_MODE_REFRESH = 3'h4,
		SDIS_MODE_LOAD_EMR = 3'h5
	} sdis_mode_type;

	typedef enum logic [1:0]
	{
		SDIS_TYPE_SDR = 2'h0,
		SDIS_TYPE_LPDDR1 = 2'h1,
		SDIS_TYPE_DDR2 = 2'h2
	} sdis_memtype_type;

	typedef enum logic [1:0]
	{
		SDIS_ST_IDLE = 2'b00,
		SDIS_ST_HOLD = 2'b01,
		SDIS_ST_ISSUE = 2'b11,
		SDIS_ST_DONE = 2'b10
	} sdis_state_type;

	typedef struct packed
	{
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] ba;
		logic [12:0] addr;
	} sdis_cmd_type;

endpackage
`default_nettype wire

// File: sdis_tick_counter.sv
// loadable down counter that finishes after a number of ticks
`timescale 1ns/1ps
`default_nettype none
module sdis_tick_counter #(
	parameter int W = 16
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire logic [W-1:0] load_i,
	input wire logic tick_i,
	output logic busy_o,
	output logic done_o
);

	logic [W-1:0] cnt_q;
	logic done_q;

	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			cnt_q <= '0;
		else if (start_i)
			cnt_q <= load_i;
		else if (tick_i && cnt_q != '0)
			cnt_q <= cnt_q - W'(1);
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			done_q <= 1'b0;
		else
			done_q <= !start_i && tick_i && cnt_q == W'(1);
	end

	assign busy_o = cnt_q != '0;
	assign done_o = done_q;

endmodule
`default_nettype wire

// File: sdis_top.sv
// sdram init command sequencer with avalon-mm register and memory port
// Functional notes
// - mode 1 write issues NOP; first one enables memory clocks
// - after first NOP wait 200 us before any other memory signal moves
// - DDR2: second NOP with mode 1 drives CKE high
// - mode 2 write issues precharge all banks
// - mode 4 write issues one auto refresh; software writes twice
// - mode 3 write issues mode register set with CAS and burst length
// - mode 5 write issues extended mode set; address bank bits pick register
// - LPDDR1 extended set carries partial-array refresh and drive strength
// - mode 0 write returns controller to normal operation
// - 200 memory clocks pass after DLL enable before next command
// - DLL reset bit set travels on following mode register set
// - refresh count sets cycles between automatic refreshes
// - memory type first; its family protocol used for later commands
// - only normal mode accepts data accesses and tracks open rows; here memory reads return zero and no rows are tracked
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sdis_regs.svh"
module sdis_top #(
	parameter int unsigned POWERUP_CYCLES = `SDIS_POWERUP_CYC
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [31:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic mem_clk_fb_i,
	output sdis_pkg::sdis_cmd_type mem_cmd_o,
	output logic mem_clk_en_o,
	output logic mem_cke_o,
	output logic normal_mode_o
);

	localparam sdis_pkg::sdis_cmd_type CMD_NOP =
		'{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
		ba: 2'h0, addr: 13'h0000};
	localparam sdis_pkg::sdis_cmd_type CMD_DESEL =
		'{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
		ba: 2'h0, addr: 13'h0000};
	localparam int MODE_W = `SDIS_MODE_W;
	localparam int RTR_W = `SDIS_RTR_W;
	localparam int TYPE_W = `SDIS_TYPE_W;

	sdis_pkg::sdis_state_type state_q;
	sdis_pkg::sdis_state_type state_d;
	sdis_pkg::sdis_mode_type mode_q;
	sdis_pkg::sdis_memtype_type type_q;
	sdis_pkg::sdis_cmd_type cmd_q;
	sdis_pkg::sdis_cmd_type cmd_d;
	logic [`SDIS_RTR_W-1:0] rtr_q;
	logic [6:0] cfg_q;
	logic [6:0] lpr_q;
	logic [31:0] rdata_q;
	logic clk_en_q;
	logic cke_q;
	logic normal_q;
	logic ref_pend_q;
	logic fb_meta_q;
	logic fb_sync_q;
	logic fb_prev_q;
	logic fb_edge;
	logic mem_hit;
	logic [1:0] bank;
	logic go;
	logic reg_wr;
	logic first_nop;
	logic dll_enable;
	logic ref_issue;
	logic pwr_busy;
	logic dll_busy;
	logic ref_busy;
	logic ref_done;
	logic [31:0] reg_rd;

	assign mem_hit = avs_address_i[`SDIS_MEM_SPACE_BIT];
	assign bank = avs_address_i[`SDIS_BA_LSB +: 2];
	assign go = state_q == sdis_pkg::SDIS_ST_HOLD && !pwr_busy && !dll_busy;
	assign reg_wr = state_q == sdis_pkg::SDIS_ST_DONE && avs_write_i &&
		!mem_hit;
	assign first_nop = go && mode_q == sdis_pkg::SDIS_MODE_NOP && !clk_en_q;
	assign dll_enable = go && mode_q == sdis_pkg::SDIS_MODE_LOAD_EMR &&
		type_q == sdis_pkg::SDIS_TYPE_DDR2 && bank == 2'h1;
	assign ref_issue = state_q == sdis_pkg::SDIS_ST_IDLE && normal_q &&
		ref_pend_q;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[8*i +: 8] = wdata[8*i +: 8];
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link clock: the memory clock comes back on a pin, only its rising edges count

	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			fb_meta_q <= 1'b0;
			fb_sync_q <= 1'b0;
			fb_prev_q <= 1'b0;
		end
		else
		begin
			fb_meta_q <= mem_clk_fb_i;
			fb_sync_q <= fb_meta_q;
			fb_prev_q <= fb_sync_q;
		end
	end

	assign fb_edge = fb_sync_q && !fb_prev_q;

	////////////////////////////////////////////////////////////////////////
	// timers: power-up pause, dll lock, refresh interval

	sdis_tick_counter #(.W(16)) u_pwr_timer (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(first_nop),
		.load_i(16'(POWERUP_CYCLES)),
		.tick_i(1'b1),
		.busy_o(pwr_busy),
		.done_o()
	);

	sdis_tick_counter #(.W(16)) u_dll_timer (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(dll_enable),
		.load_i(16'(`SDIS_DLL_LOCK_CLKS)),
		.tick_i(fb_edge),
		.busy_o(dll_busy),
		.done_o()
	);

	// interval is count plus one cycle for the reload
	sdis_tick_counter #(.W(16)) u_ref_timer (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(normal_q && rtr_q != '0 && !ref_busy),
		.load_i(16'(rtr_q)),
		.tick_i(1'b1),
		.busy_o(ref_busy),
		.done_o(ref_done)
	);

	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ref_pend_q <= 1'b0;
		else if (ref_done)
			ref_pend_q <= 1'b1;
		else if (ref_issue || !normal_q)
			ref_pend_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// bus access sequencing

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			sdis_pkg::SDIS_ST_IDLE:
				if (avs_read_i || avs_write_i)
				begin
					if (mem_hit && avs_write_i &&
						mode_q != sdis_pkg::SDIS_MODE_NORMAL)
						state_d = sdis_pkg::SDIS_ST_HOLD;
					else
						state_d = sdis_pkg::SDIS_ST_DONE;
				end
			sdis_pkg::SDIS_ST_HOLD:
				if (go)
					state_d = sdis_pkg::SDIS_ST_ISSUE;
			sdis_pkg::SDIS_ST_ISSUE:
				state_d = sdis_pkg::SDIS_ST_DONE;
			sdis_pkg::SDIS_ST_DONE:
				state_d = sdis_pkg::SDIS_ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			state_q <= sdis_pkg::SDIS_ST_IDLE;
		else
			state_q <= state_d;
	end

	assign avs_waitrequest_o = state_q != sdis_pkg::SDIS_ST_DONE;

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			mode_q <= sdis_pkg::sdis_mode_type'(`SDIS_MODE_RST);
			rtr_q <= `SDIS_RTR_RST;
			cfg_q <= `SDIS_CFG_RST;
			lpr_q <= `SDIS_LPR_RST;
			type_q <= sdis_pkg::sdis_memtype_type'(`SDIS_TYPE_RST);
		end
		else if (reg_wr)
		begin
			unique case (avs_address_i[7:0])
				`SDIS_OFS_MODE:
					mode_q <= sdis_pkg::sdis_mode_type'(MODE_W'(merge(
						32'(mode_q), avs_writedata_i, avs_byteenable_i)));
				`SDIS_OFS_RTR:
					rtr_q <= RTR_W'(merge(32'(rtr_q), avs_writedata_i,
						avs_byteenable_i));
				`SDIS_OFS_CFG:
					cfg_q <= 7'(merge(32'(cfg_q), avs_writedata_i,
						avs_byteenable_i));
				`SDIS_OFS_LPR:
					lpr_q <= 7'(merge(32'(lpr_q), avs_writedata_i,
						avs_byteenable_i));
				`SDIS_OFS_TYPE:
					type_q <= sdis_pkg::sdis_memtype_type'(TYPE_W'(merge(
						32'(type_q), avs_writedata_i,
						avs_byteenable_i)));
				default:
					;
			endcase
		end
	end

	always_comb
	begin
		unique case (avs_address_i[7:0])
			`SDIS_OFS_MODE: reg_rd = 32'(mode_q);
			`SDIS_OFS_RTR: reg_rd = 32'(rtr_q);
			`SDIS_OFS_CFG: reg_rd = 32'(cfg_q);
			`SDIS_OFS_LPR: reg_rd = 32'(lpr_q);
			`SDIS_OFS_TYPE: reg_rd = 32'(type_q);
			`SDIS_OFS_STATUS: reg_rd = {26'h0000000, ref_pend_q, normal_q,
				dll_busy, pwr_busy, cke_q, clk_en_q};
			default: reg_rd = 32'h00000000;
		endcase
	end

	// memory-space reads return zero; the data path lives elsewhere
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rdata_q <= 32'h00000000;
		else if (state_q == sdis_pkg::SDIS_ST_IDLE && avs_read_i)
			rdata_q <= mem_hit ? 32'h00000000 : reg_rd;
	end

	assign avs_readdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// memory command generation

	always_comb
	begin
		cmd_d = clk_en_q ? CMD_NOP : CMD_DESEL;
		if (go)
		begin
			cmd_d.ba = bank;
			unique case (mode_q)
				sdis_pkg::SDIS_MODE_PRECHARGE:
				begin
					cmd_d.ras_n = 1'b0;
					cmd_d.we_n = 1'b0;
					cmd_d.addr[`SDIS_A_AP] = 1'b1;
				end
				sdis_pkg::SDIS_MODE_REFRESH:
				begin
					cmd_d.ras_n = 1'b0;
					cmd_d.cas_n = 1'b0;
				end
				sdis_pkg::SDIS_MODE_LOAD_MR:
				begin
					{cmd_d.ras_n, cmd_d.cas_n, cmd_d.we_n} = 3'h0;
					cmd_d.addr[`SDIS_A_BL_LSB +: 3] = `SDIS_BL8_CODE;
					cmd_d.addr[`SDIS_A_CAS_LSB +: 3] =
						cfg_q[`SDIS_CFG_CAS_LSB +: 3];
					cmd_d.addr[`SDIS_A_DLL_RST] =
						type_q == sdis_pkg::SDIS_TYPE_DDR2 &&
						cfg_q[`SDIS_CFG_DLL_BIT];
				end
				sdis_pkg::SDIS_MODE_LOAD_EMR:
				begin
					{cmd_d.ras_n, cmd_d.cas_n, cmd_d.we_n} = 3'h0;
					if (type_q == sdis_pkg::SDIS_TYPE_DDR2)
					begin
						// bank 3 loads zero, bank 1 leaves the dll enabled
						if (bank == 2'h2)
							cmd_d.addr[`SDIS_A_EMR2_HT] = cfg_q[`SDIS_CFG_HT_BIT];
						if (bank == 2'h1)
							cmd_d.addr[`SDIS_A_EMR1_WEAK] =
								cfg_q[`SDIS_CFG_WEAK_BIT];
					end
					else
					begin
						cmd_d.addr[`SDIS_A_EMR_ARRAY_LSB +: 3] =
							lpr_q[`SDIS_LP_ARRAY_LSB +: 3];
						cmd_d.addr[`SDIS_A_EMR_DRIVE_LSB +: 2] =
							lpr_q[`SDIS_LP_DRIVE_LSB +: 2];
					end
				end
				default:
				begin
					// the nop itself goes out selected, also the first one
					cmd_d.cs_n = 1'b0;
					cmd_d.ba = 2'h0;
				end
			endcase
		end
		else if (ref_issue)
		begin
			cmd_d.ras_n = 1'b0;
			cmd_d.cas_n = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			cmd_q <= CMD_DESEL;
		else
			cmd_q <= cmd_d;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			clk_en_q <= 1'b0;
			cke_q <= 1'b0;
		end
		else if (go && mode_q == sdis_pkg::SDIS_MODE_NOP)
		begin
			clk_en_q <= 1'b1;
			// ddr2 needs a second nop to raise cke
			if (type_q != sdis_pkg::SDIS_TYPE_DDR2 || clk_en_q)
				cke_q <= 1'b1;
		end
	end

	// automatic refresh timing and refresh issue are gated by this flag
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			normal_q <= 1'b0;
		else if (state_q == sdis_pkg::SDIS_ST_DONE && avs_write_i && mem_hit &&
			mode_q == sdis_pkg::SDIS_MODE_NORMAL)
			normal_q <= 1'b1;
		else if (reg_wr && avs_address_i[7:0] == `SDIS_OFS_MODE &&
			avs_byteenable_i[0] && avs_writedata_i[`SDIS_MODE_W-1:0] != 3'h0)
			normal_q <= 1'b0;
	end

	assign mem_cmd_o = cmd_q;
	assign mem_clk_en_o = clk_en_q;
	assign mem_cke_o = cke_q;
	assign normal_mode_o = normal_q;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_issue(sdis_pkg::sdis_mode_type m);
		go && mode_q == m;
	endsequence

	sequence s_close;
		state_q == sdis_pkg::SDIS_ST_ISSUE ##1
		state_q == sdis_pkg::SDIS_ST_DONE && !avs_waitrequest_o ##1
		state_q == sdis_pkg::SDIS_ST_IDLE;
	endsequence

	a_nop_clk_on: assert property (s_issue(sdis_pkg::SDIS_MODE_NOP) |=>
		clk_en_q && !cmd_q.cs_n &&
		{cmd_q.ras_n, cmd_q.cas_n, cmd_q.we_n} == 3'h7)
		else $error("nop did not enable memory clocks");

	// the first nop's own edge launches the pause, so it is left out
	a_powerup_quiet: assert property (pwr_busy && $past(pwr_busy) |->
		state_q != sdis_pkg::SDIS_ST_ISSUE && $stable(cke_q))
		else $error("memory signal moved during power-up pause");

	a_ddr2_cke_rise: assert property (
		s_issue(sdis_pkg::SDIS_MODE_NOP) ##0
		(type_q == sdis_pkg::SDIS_TYPE_DDR2 && !clk_en_q) |=> !cke_q)
		else $error("cke rose on first ddr2 nop");

	a_precharge_all: assert property (
		s_issue(sdis_pkg::SDIS_MODE_PRECHARGE) |=> !cmd_q.ras_n &&
		cmd_q.cas_n && !cmd_q.we_n && cmd_q.addr[`SDIS_A_AP])
		else $error("precharge all not issued");

	a_refresh_cmd: assert property (
		s_issue(sdis_pkg::SDIS_MODE_REFRESH) |=> !cmd_q.ras_n &&
		!cmd_q.cas_n && cmd_q.we_n ##1 cmd_q.ras_n)
		else $error("refresh not a single command");

	a_mr_dll_reset: assert property (
		s_issue(sdis_pkg::SDIS_MODE_LOAD_MR) |=>
		cmd_q.addr[`SDIS_A_DLL_RST] == ($past(cfg_q[`SDIS_CFG_DLL_BIT]) &&
		$past(type_q) == sdis_pkg::SDIS_TYPE_DDR2))
		else $error("dll reset bit not carried");

	a_emr_bank_sel: assert property (
		s_issue(sdis_pkg::SDIS_MODE_LOAD_EMR) |=> cmd_q.ba == $past(bank) &&
		!cmd_q.ras_n && !cmd_q.cas_n && !cmd_q.we_n)
		else $error("extended set bank mismatch");

	a_lp_emr_fields: assert property (
		s_issue(sdis_pkg::SDIS_MODE_LOAD_EMR) ##0
		(type_q == sdis_pkg::SDIS_TYPE_LPDDR1) |=>
		cmd_q.addr[`SDIS_A_EMR_ARRAY_LSB +: 3] ==
		lpr_q[`SDIS_LP_ARRAY_LSB +: 3] &&
		cmd_q.addr[`SDIS_A_EMR_DRIVE_LSB +: 2] ==
		lpr_q[`SDIS_LP_DRIVE_LSB +: 2])
		else $error("low-power fields not carried");

	a_dll_lock_gap: assert property (dll_enable |=>
		dll_busy [*3] ##0 state_q != sdis_pkg::SDIS_ST_ISSUE)
		else $error("dll lock wait not held");

	a_one_command: assert property (go |=> s_close)
		else $error("memory write did not complete with one command");

	a_normal_entry: assert property (
		(state_q == sdis_pkg::SDIS_ST_DONE && avs_write_i && mem_hit &&
		mode_q == sdis_pkg::SDIS_MODE_NORMAL) |=> normal_q)
		else $error("normal mode not entered");

endmodule
`default_nettype wire

// File: sdis_mem_model.sv
// behavioural sdram partner: returns the memory clock and logs commands
`timescale 1ns/1ps
`default_nettype none
module sdis_mem_model (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire sdis_pkg::sdis_cmd_type cmd_i,
	input wire logic clk_en_i,
	output logic mem_clk_o,
	output logic [7:0] cmd_cnt_o,
	output sdis_pkg::sdis_cmd_type last_cmd_o,
	output logic [15:0] last_gap_o
);
	logic [15:0] gap_q;
	logic hit;

	// nop and deselect carry no work, so only real commands are logged
	assign hit = !cmd_i.cs_n && ({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n} != 3'h7);

	////////////////////////////////////////////////////////////////////////
	// clock stands low until enabled; odd start offset keeps phase unrelated
	initial
	begin
		mem_clk_o = 1'b0;
		#5;
		forever
		begin
			#32;
			mem_clk_o = clk_en_i ? ~mem_clk_o : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cmd_cnt_o <= 8'h00;
			last_cmd_o <= '0;
			gap_q <= 16'h0000;
			last_gap_o <= 16'h0000;
		end
		else
		begin
			gap_q <= hit ? 16'h0001 : gap_q + 16'h0001;
			if (hit)
			begin
				cmd_cnt_o <= cmd_cnt_o + 8'h01;
				last_cmd_o <= cmd_i;
				last_gap_o <= gap_q;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the sdram init command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int PWR = 20;
	localparam logic [31:0] MEM = 32'h2000_0000;
	localparam logic [18:0] ALL = 19'h7ffff;
	localparam logic [18:0] PRE = {4'b0010, 15'h0400};
	localparam logic [18:0] REF = {4'b0001, 15'h0000};
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [31:0] avs_address_i = 32'h0000_0000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic mem_clk;
	sdis_pkg::sdis_cmd_type mem_cmd_o;
	sdis_pkg::sdis_cmd_type last;
	logic mem_clk_en_o, mem_cke_o, normal_mode_o;
	logic [7:0] cnt;
	logic [15:0] gap;
	logic [31:0] rd;
	logic [7:0] c_ref;
	int cyc, n_errors = 0, tests_run = 0, cyc_total = 0;

	always #4 core_clk_i = ~core_clk_i;

	sdis_top #(.POWERUP_CYCLES(PWR)) uut (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .mem_clk_fb_i(mem_clk),
		.mem_cmd_o(mem_cmd_o), .mem_clk_en_o(mem_clk_en_o),
		.mem_cke_o(mem_cke_o), .normal_mode_o(normal_mode_o));

	sdis_mem_model mem (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cmd_i(mem_cmd_o),
		.clk_en_i(mem_clk_en_o), .mem_clk_o(mem_clk), .cmd_cnt_o(cnt),
		.last_cmd_o(last), .last_gap_o(gap));

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one avalon access; held until waitrequest is sampled low at a rise
	task automatic acc(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q, output int c);
		c = 0;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= ~w;
		do
		begin
			@(posedge core_clk_i);
			c++;
		end
		while (avs_waitrequest_o !== 1'b0 && c < 5000);
		if (c >= 5000)
			chk(32'h0, 32'h1);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		acc(1'b1, a, d, rd, cyc);
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0, rd, cyc);
		chk(rd, e);
	endtask

	// set the command mode, write the memory space, check what went out
	task automatic cmd(input logic [2:0] m, input logic [1:0] ba,
		input int n, input logic [18:0] e, input logic [18:0] k);
		logic [7:0] c0;
		wr(32'h0, {29'h0, m});
		c0 = cnt;
		acc(1'b1, MEM | {8'h00, ba, 22'h0}, 32'h0, rd, cyc);
		chk(cnt - c0, n);
		if (n > 0)
			chk(last & k, e & k);
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk_i)
	begin
		cyc_total++;
		if (cyc_total > 20000)
		begin
			n_errors++;
			end_sim;
		end
	end

	initial
	begin
		repeat (8) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		rdc(32'h00, 32'h0);
		rdc(32'h04, 32'h0);
		rdc(32'h08, 32'h3);
		rdc(32'h0c, 32'h0);
		rdc(32'h10, 32'h0);
		wr(32'h14, 32'hff);
		rdc(32'h14, 32'h0);
		wr(32'h18, 32'h5);
		rdc(32'h18, 32'h0);
		// low-power ddr1 bring-up
		wr(32'h10, 32'h1);
		wr(32'h08, 32'h2);
		wr(32'h0c, 32'h45);
		cmd(3'h1, 2'h0, 0, 19'h0, 19'h0);
		chk({mem_clk_en_o, mem_cke_o, normal_mode_o}, 3'b110);
		cmd(3'h2, 2'h0, 1, PRE, 19'h78400);
		chk(cyc > PWR - 6, 1);
		cmd(3'h4, 2'h0, 1, REF, 19'h78000);
		cmd(3'h4, 2'h0, 1, REF, 19'h78000);
		cmd(3'h5, 2'h2, 1, {4'h0, 2'h2, 13'h0045}, ALL);
		cmd(3'h3, 2'h0, 1, {4'h0, 2'h0, 13'h0023}, ALL);
		chk(normal_mode_o, 1'b0);
		wr(32'h00, 32'h0);
		wr(MEM, 32'h0);
		// normal flag moves on the answer edge itself
		@(negedge core_clk_i);
		chk(normal_mode_o, 1'b1);
		wr(MEM | 32'h40, 32'h1234);
		c_ref = cnt;
		wr(32'h04, 32'h00a);
		repeat (40) @(posedge core_clk_i);
		chk(cnt - c_ref >= 8'h03, 1);
		chk(gap >= 16'd11 && gap <= 16'd12, 1);
		chk(last & 19'h78000, REF);
		// second reset in mid-run, then ddr2 bring-up
		sys_rst_i <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		chk({mem_clk_en_o, mem_cke_o, normal_mode_o}, 3'b000);
		wr(32'h10, 32'h2);
		wr(32'h08, 32'h63);
		cmd(3'h1, 2'h0, 0, 19'h0, 19'h0);
		chk({mem_clk_en_o, mem_cke_o}, 2'b10);
		cmd(3'h1, 2'h0, 0, 19'h0, 19'h0);
		chk(cyc > PWR - 6, 1);
		chk(mem_cke_o, 1'b1);
		cmd(3'h2, 2'h0, 1, PRE, 19'h78400);
		cmd(3'h5, 2'h2, 1, {4'h0, 2'h2, 13'h0080}, ALL);
		cmd(3'h5, 2'h3, 1, {4'h0, 2'h3, 13'h0000}, ALL);
		cmd(3'h5, 2'h1, 1, {4'h0, 2'h1, 13'h0002}, ALL);
		wr(32'h08, 32'h73);
		cmd(3'h3, 2'h0, 1, {4'h0, 2'h0, 13'h0133}, ALL);
		chk(cyc > 1500, 1);
		cmd(3'h2, 2'h0, 1, PRE, 19'h78400);
		cmd(3'h4, 2'h0, 1, REF, 19'h78000);
		cmd(3'h4, 2'h0, 1, REF, 19'h78000);
		end_sim;
	end
endmodule
`default_nettype wire
